//--- rtl/dyr_apb_regs.sv
/*
  APB slave holding the control registers and the status read-back.
  Assumes zero-wait APB with 32-bit data; read data is captured in setup.
*/
`timescale 1ns/1ps
module dyr_apb_regs (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Register contents and status.
  input  wire logic [15:0] status,
  output logic      [15:0] ctrl1,
  output logic      [15:0] ctrl3,
  output logic      [15:0] ctrl4,
  output logic             run
);

  typedef struct packed {
    logic [15:0] c1;
    logic [15:0] c3;
    logic [15:0] c4;
    logic        run;
    logic [31:0] rdata;
  } dyr_regs_t;

  dyr_regs_t   st;
  dyr_regs_t   next_st;
  logic [7:0]  idx;
  logic        aligned;
  logic        mapped;
  logic [15:0] rd_val;

  assign idx     = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign rd_val  = (idx == dyr_pkg::IDX_CTRL1)  ? st.c1 :
                   (idx == dyr_pkg::IDX_CTRL3)  ? st.c3 :
                   (idx == dyr_pkg::IDX_CTRL4)  ? st.c4 :
                   (idx == dyr_pkg::IDX_RUN)    ? {15'h0000, st.run} :
                   (idx == dyr_pkg::IDX_STATUS) ? status : 16'h0000;
  assign mapped  = aligned && (idx >= dyr_pkg::IDX_RUN) && (idx <= dyr_pkg::IDX_STATUS)
                   && (idx != 8'h7c);

  always_comb
  begin
    next_st = st;
    if (psel && !penable)
    begin
      next_st.rdata = {16'h0000, rd_val};
    end
    if (psel && penable && pwrite && mapped)
    begin
      case (idx)
        dyr_pkg::IDX_CTRL1: next_st.c1 = pwdata[15:0] & dyr_pkg::MASK_CTRL1;
        dyr_pkg::IDX_CTRL3: next_st.c3 = pwdata[15:0] & dyr_pkg::MASK_CTRL3;
        dyr_pkg::IDX_CTRL4: next_st.c4 = pwdata[15:0] & dyr_pkg::MASK_CTRL4;
        dyr_pkg::IDX_RUN:   next_st.run = pwdata[0];
        default:            next_st.run = st.run;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '{c1: dyr_pkg::RST_CTRL1, c3: dyr_pkg::RST_CTRL3, c4: dyr_pkg::RST_CTRL4, default: '0};
    else
      st <= next_st;
  end

  assign prdata  = st.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign ctrl1   = st.c1;
  assign ctrl3   = st.c3;
  assign ctrl4   = st.c4;
  assign run     = st.run;

endmodule : dyr_apb_regs

//--- rtl/dyr_lookahead.sv
/*
  Look-ahead delay line for the clip guard: nine sample taps in flip-flops.
  Assumes shift is a one-cycle pulse per input sample on the same clock.
*/
`timescale 1ns/1ps
module dyr_lookahead (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Sample stream.
  input  wire logic        shift,
  input  wire logic [15:0] din,
  input  wire logic        long_sel,
  output logic      [15:0] dout
);

  typedef struct packed {
    logic [dyr_pkg::LA_LONG-1:0][15:0] tap;
  } dyr_tap_t;

  dyr_tap_t st;
  dyr_tap_t next_st;

  always_comb
  begin
    next_st = st;
    if (shift)
    begin
      next_st.tap = {st.tap[dyr_pkg::LA_LONG-2:0], din};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  // Read before the shift, tap k holds the sample from k+1 samples ago.
  assign dout = long_sel ? st.tap[dyr_pkg::LA_LONG-1] : st.tap[dyr_pkg::LA_SHORT-1]; // RULE2

endmodule : dyr_lookahead

//--- rtl/dyr_pkg.sv
/*
  Shared constants for the dynamic range controller: register indices, field
  positions, reset values, gain limits and the sample-rate time base.
  Assumes one clock domain and an APB register port with 32-bit data.
*/
// Behaviour
// RULE1 - Clip guard on: look ahead at rising input, speed up gain attack to avoid clipping.
// RULE2 - Look-ahead delay is 5 samples when select is 0, 9 samples when 1.
// RULE3 - Look-ahead delay adds latency; clip guard off removes it.
// RULE4 - Fast release on: keep measuring input crest factor, peak over RMS.
// RULE5 - Crest factor above threshold: use fast release rate instead of normal release.
// RULE6 - Crest threshold code selects 12, 18, 24 or 30 dB.
// RULE7 - Fast release rate code selects 0.725, 1.45 or 5.8 ms per 6 dB.
// RULE8 - Smoothing on filters the gain against ripple; off bypasses the filter.
// RULE9 - Hysteresis on holds gain against small back-and-forth changes.
// RULE10 - Hysteresis level code selects low, medium or high band.
// RULE11 - Software should leave smoothing and hysteresis fields at reset values.
// RULE12 - On initialisation the applied gain loads from the initial gain code.
// RULE13 - Initial gain code 0 is -18 dB, 3 dB steps, up to 36 dB.
// RULE14 - Normal release raises gain on low signal; attack lowers it on high.
// RULE15 - Control fields are taken at sample boundaries, one set per sample.
package dyr_pkg;

  // Register indices; the byte address of each is four times its index.
  localparam logic [7:0]  IDX_RUN       = 8'h7a;
  localparam logic [7:0]  IDX_CTRL1     = 8'h7b;
  localparam logic [7:0]  IDX_CTRL3     = 8'h7d;
  localparam logic [7:0]  IDX_CTRL4     = 8'h7e;
  localparam logic [7:0]  IDX_STATUS    = 8'h7f;

  localparam logic [15:0] RST_CTRL1     = 16'h0f10;
  localparam logic [15:0] RST_CTRL3     = 16'h0084;
  localparam logic [15:0] RST_CTRL4     = 16'h0600;
  localparam logic [15:0] MASK_CTRL1    = 16'h0f30;
  localparam logic [15:0] MASK_CTRL3    = 16'h008f;
  localparam logic [15:0] MASK_CTRL4    = 16'h1f00;

  localparam int          BIT_SMOOTH    = 11;
  localparam int          BIT_FAST      = 10;
  localparam int          BIT_CLIP      = 9;
  localparam int          BIT_HYST      = 8;
  localparam int          POS_HYST_LVL  = 4;
  localparam int          BIT_LA_SEL    = 7;
  localparam int          POS_CREST     = 2;
  localparam int          POS_FRATE     = 0;
  localparam int          POS_INIT      = 8;
  localparam int          POS_ST_FAST   = 8;
  localparam int          POS_ST_CLIP   = 9;

  localparam int          LA_SHORT      = 5;
  localparam int          LA_LONG       = 9;

  // Gain is kept in steps of 0.75 dB, eight steps to 6 dB.
  localparam logic signed [7:0]  GAIN_MIN      = -8'sh18;
  localparam logic signed [7:0]  GAIN_MAX      = 8'sh30;
  localparam logic signed [7:0]  INIT_OFS      = 8'sh18;
  localparam logic [4:0]         INIT_CODE_MAX = 5'h12;
  localparam logic signed [16:0] LEVEL_TARGET  = 17'sh02000;
  localparam logic signed [16:0] FULL_SCALE    = 17'sh07fff;
  localparam int          AVG_SHIFT     = 6;
  localparam int          PEAK_SHIFT    = 8;
  localparam int          SMOOTH_SHIFT  = 2;
  localparam int          SM_FRAC       = 4;
  localparam int          CREST_BASE    = 2;
  localparam int          MANT_FRAC     = 14;

  // Time base: rates count samples, not clock cycles.
  localparam longint      FS_HZ         = 48000;
  localparam longint      STEPS_PER_6DB = 8;
  localparam longint      US_PER_S      = 1000000;
  localparam longint      FAST_US_0     = 725;
  localparam longint      FAST_US_1     = 1450;
  localparam longint      FAST_US_2     = 5800;

  // Samples per 0.75 dB step for a rate given in microseconds per 6 dB.
  function automatic logic [19:0] rate_samples(input longint t_us);
    longint n;
    n = t_us * FS_HZ / (STEPS_PER_6DB * US_PER_S);
    if (n < 1)
    begin
      n = 1;
    end
    return 20'(n);
  endfunction : rate_samples

endpackage : dyr_pkg

//--- rtl/dyr_range_ctrl.sv
/*
  Dynamic range controller gain core: clip guard with look-ahead, crest-factor
  fast release, gain hysteresis and smoothing, and start-up gain.
  Assumes samples arrive as one-cycle pulses on pclk, at least two cycles apart,
  and that attack and normal release rate codes come in on their own input ports, not from the register bank.
*/
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module dyr_range_ctrl (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB register port.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Rate selections from the compressor settings.
  input  wire logic [3:0]  gain_attack_rate,
  input  wire logic [3:0]  normal_release_rate,
  // Sample stream.
  input  wire logic [15:0] sample_in,
  input  wire logic        sample_valid,
  output logic      [15:0] sample_out,
  output logic             sample_out_valid
);

  typedef struct packed {
    logic [15:0]        sh_c1;
    logic [15:0]        sh_c3;
    logic [15:0]        sh_c4;
    logic               sh_run;
    logic [3:0]         sh_atk;
    logic [3:0]         sh_dec;
    logic [15:0]        avg;
    logic [15:0]        peak;
    logic [19:0]        cnt;
    logic signed [7:0]  g_raw;
    logic signed [7:0]  g_app;
    logic signed [11:0] g_sm;
    logic               fast;
    logic               clip;
    logic [15:0]        out;
    logic               out_v;
  } dyr_core_t;

  localparam dyr_core_t RST_ST = '{sh_c1: dyr_pkg::RST_CTRL1, sh_c3: dyr_pkg::RST_CTRL3,
                                   sh_c4: dyr_pkg::RST_CTRL4, default: '0};

  // Fraction of 2^(k*0.75/6) in Q1.14 for the low three gain bits.
  function automatic logic [15:0] mant(input logic [2:0] k);
    case (k)
      3'h0:    return 16'h4000;
      3'h1:    return 16'h45ca;
      3'h2:    return 16'h4c1c;
      3'h3:    return 16'h52ff;
      3'h4:    return 16'h5a82;
      3'h5:    return 16'h62b3;
      3'h6:    return 16'h6ba2;
      default: return 16'h7560;
    endcase
  endfunction : mant

  // Applies a gain in 0.75 dB steps to a sample and saturates the result.
  function automatic logic signed [16:0] apply(input logic signed [16:0] x,
                                               input logic signed [7:0]  g);
    logic signed [40:0] p;
    logic signed [7:0]  e;
    p = x;
    p = p * $signed({25'h0000000, mant(g[2:0])});
    e = g >>> 3;
    if (e >= 0)
      p = p <<< e;
    else
      p = p >>> (-e);
    p = p >>> dyr_pkg::MANT_FRAC;
    if (p > dyr_pkg::FULL_SCALE)
      return dyr_pkg::FULL_SCALE;
    if (p < -dyr_pkg::FULL_SCALE)
      return -dyr_pkg::FULL_SCALE;
    return p[16:0];
  endfunction : apply

  // One 0.75 dB step up or down, held inside the gain limits.
  function automatic logic signed [7:0] step(input logic signed [7:0] g, input logic up);
    if (up)
      return (g >= dyr_pkg::GAIN_MAX) ? dyr_pkg::GAIN_MAX : g + 8'sh01;
    return (g <= dyr_pkg::GAIN_MIN) ? dyr_pkg::GAIN_MIN : g - 8'sh01;
  endfunction : step

  // Attack time per 6 dB in microseconds; reserved codes take the nearest end.
  function automatic longint atk_us(input logic [3:0] c);
    case (c)
      4'h2:    return 363;
      4'h3:    return 726;
      4'h4:    return 1450;
      4'h5:    return 2900;
      4'h6:    return 5800;
      4'h7:    return 11600;
      4'h8:    return 23200;
      4'h9:    return 46400;
      4'ha:    return 92800;
      4'hb:    return 185600;
      4'hc,
      4'hd,
      4'he,
      4'hf:    return 185600;
      default: return 181;
    endcase
  endfunction : atk_us

  // Normal release time per 6 dB in microseconds.
  function automatic longint dec_us(input logic [3:0] c);
    case (c)
      4'h0:    return 186000;
      4'h1:    return 372000;
      4'h2:    return 743000;
      4'h3:    return 1490000;
      4'h4:    return 2970000;
      4'h5:    return 5940000;
      4'h6:    return 11890000;
      4'h7:    return 23780000;
      default: return 47560000;
    endcase
  endfunction : dec_us

  // Fast release time per 6 dB; the reserved code is taken as the slowest.
  function automatic longint fast_us(input logic [1:0] c);
    case (c)
      2'h0:    return dyr_pkg::FAST_US_0;
      2'h1:    return dyr_pkg::FAST_US_1;
      default: return dyr_pkg::FAST_US_2;
    endcase
  endfunction : fast_us

  dyr_core_t          st;
  dyr_core_t          next_st;
  logic [15:0]        ctrl1;
  logic [15:0]        ctrl3;
  logic [15:0]        ctrl4;
  logic               run;
  logic [15:0]        status;
  logic [15:0]        la_out;
  logic               clip_en;
  logic               fast_en;
  logic               smooth_en;
  logic               hyst_en;
  logic [1:0]         hyst_lvl;
  logic [1:0]         crest_sel;
  logic [4:0]         init_code;
  logic signed [7:0]  init_g;
  logic [15:0]        src;
  logic [15:0]        ax;
  logic signed [17:0] avg_d;
  logic signed [16:0] lvl;
  logic               high;
  logic signed [16:0] pred;
  logic               clip_now;
  logic [20:0]        crest_lim;
  logic               fast_now;
  logic [19:0]        atk_n;
  logic [19:0]        dec_n;
  logic [19:0]        fast_n;
  logic [19:0]        interval;
  logic               step_due;
  logic signed [7:0]  raw_next;
  logic signed [8:0]  gap;
  logic signed [8:0]  hyst_n;
  logic               hyst_hold;
  logic signed [7:0]  g_out;
  logic signed [16:0] out_full;

  dyr_apb_regs u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .status  (status),
    .ctrl1   (ctrl1),
    .ctrl3   (ctrl3),
    .ctrl4   (ctrl4),
    .run     (run)
  );

  dyr_lookahead u_look (
    .pclk     (pclk),
    .presetn  (presetn),
    .shift    (sample_valid),
    .din      (sample_in),
    .long_sel (st.sh_c3[dyr_pkg::BIT_LA_SEL]),
    .dout     (la_out)
  );

  // Field decode from the settings held for the current sample.
  assign clip_en   = st.sh_c1[dyr_pkg::BIT_CLIP];
  assign fast_en   = st.sh_c1[dyr_pkg::BIT_FAST];
  assign smooth_en = st.sh_c1[dyr_pkg::BIT_SMOOTH];
  assign hyst_en   = st.sh_c1[dyr_pkg::BIT_HYST];
  assign hyst_lvl  = st.sh_c1[dyr_pkg::POS_HYST_LVL +: 2];
  assign crest_sel = st.sh_c3[dyr_pkg::POS_CREST +: 2];
  assign init_code = st.sh_c4[dyr_pkg::POS_INIT +: 5];

  // Codes above the top step are held at 36 dB.
  assign init_g = (init_code > dyr_pkg::INIT_CODE_MAX) ? dyr_pkg::GAIN_MAX
                : 8'($signed({1'b0, init_code, 2'b00}) - dyr_pkg::INIT_OFS); // RULE13

  // Without the clip guard the output takes the live sample, no added latency.
  assign src = clip_en ? la_out : sample_in; // RULE3

  assign ax    = sample_in[15] ? 16'(-sample_in) : sample_in;
  assign avg_d = $signed({2'b00, ax}) - $signed({2'b00, st.avg});

  // The loop level uses the running average as an RMS estimate.
  assign lvl  = apply($signed({1'b0, st.avg}), st.g_raw);
  assign high = lvl > dyr_pkg::LEVEL_TARGET;

  // The live sample is seen before its delayed copy reaches the output.
  assign pred     = apply($signed({1'b0, ax}), st.g_app);
  assign clip_now = clip_en && (pred >= dyr_pkg::FULL_SCALE); // RULE1

  // Crest thresholds of 12 to 30 dB are peak-to-average ratios of 4 to 32.
  assign crest_lim = {5'h00, st.avg} << (3'(crest_sel) + 3'(dyr_pkg::CREST_BASE)); // RULE6
  assign fast_now  = fast_en && ({5'h00, st.peak} > crest_lim); // RULE4

  assign atk_n    = dyr_pkg::rate_samples(atk_us(st.sh_atk));
  assign dec_n    = dyr_pkg::rate_samples(dec_us(st.sh_dec));
  assign fast_n   = dyr_pkg::rate_samples(fast_us(st.sh_c3[dyr_pkg::POS_FRATE +: 2])); // RULE7
  assign interval = high ? atk_n : (fast_now ? fast_n : dec_n); // RULE5 RULE14
  assign step_due = ({1'b0, st.cnt} + 21'h000001) >= {1'b0, interval};

  // Clip guard steps the gain down every sample, overriding the attack rate.
  assign raw_next = clip_now ? step(st.g_raw, 1'b0) : // RULE1
                    step_due ? step(st.g_raw, !high) : st.g_raw; // RULE14

  // A reserved hysteresis code is taken as the high band.
  assign hyst_n    = (hyst_lvl == 2'h3) ? 9'sh003 : $signed({7'h00, hyst_lvl}) + 9'sh001; // RULE10
  assign gap       = $signed({raw_next[7], raw_next}) - $signed({st.g_app[7], st.g_app});
  assign hyst_hold = hyst_en && !clip_now && (gap < hyst_n) && (gap > -hyst_n); // RULE9

  assign g_out = 8'((st.g_sm + 12'sh008) >>> dyr_pkg::SM_FRAC);

  // A function result cannot be part-selected, so the full product is kept as a net.
  assign out_full = apply($signed({src[15], src}), g_out);

  always_comb
  begin
    next_st       = st;
    next_st.out_v = 1'b0;
    if (sample_valid)
    begin
      // New settings only take effect between samples.
      next_st.sh_c1  = ctrl1; // RULE15
      next_st.sh_c3  = ctrl3;
      next_st.sh_c4  = ctrl4;
      next_st.sh_run = run;
      next_st.sh_atk = gain_attack_rate;
      next_st.sh_dec = normal_release_rate;
      next_st.out    = out_full[15:0];
      next_st.out_v  = 1'b1;
      next_st.avg    = st.avg + 16'(avg_d >>> dyr_pkg::AVG_SHIFT);
      next_st.peak   = (ax > st.peak) ? ax : st.peak - (st.peak >> dyr_pkg::PEAK_SHIFT);
      next_st.fast   = fast_now;
      next_st.clip   = clip_now;
      if (!st.sh_run)
      begin
        // Held in initialisation while stopped; the loop starts from here.
        next_st.g_raw = init_g; // RULE12
        next_st.g_app = init_g;
        next_st.g_sm  = {init_g, 4'h0};
        next_st.cnt   = 20'h00000;
      end
      else
      begin
        next_st.g_raw = raw_next;
        next_st.cnt   = (clip_now || step_due) ? 20'h00000 : st.cnt + 20'h00001;
        if (!hyst_hold)
        begin
          next_st.g_app = raw_next; // RULE9
        end
        if (smooth_en)
          next_st.g_sm = st.g_sm + (($signed({next_st.g_app, 4'h0}) - st.g_sm) >>> dyr_pkg::SMOOTH_SHIFT); // RULE8
        else
          next_st.g_sm = {next_st.g_app, 4'h0}; // RULE8
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= RST_ST;
    else
      st <= next_st;
  end

  assign status           = {6'h00, st.clip, st.fast, st.g_app};
  assign sample_out       = st.out;
  assign sample_out_valid = st.out_v;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_CLIP_STEP: assert property (sample_valid && st.sh_run && clip_now && st.g_raw > dyr_pkg::GAIN_MIN // RULE1
    |=> st.g_raw == $past(st.g_raw) - 8'sh01 && st.cnt == 20'h00000)
    else $error("clip guard did not step gain down");

  AST_NO_LATENCY: assert property (sample_valid && !clip_en && g_out == 8'sh00 && sample_in != 16'h8000 // RULE3
    |=> sample_out == $past(sample_in))
    else $error("look-ahead latency present with clip guard off");

  AST_CREST_OFF: assert property (sample_valid && !fast_en |=> !st.fast) // RULE4
    else $error("crest detection active while fast release is off");

  AST_FAST_RATE: assert property (sample_valid && !high && fast_now |-> interval == fast_n) // RULE5
    else $error("fast release rate not used on high crest factor");

  AST_SMOOTH_BYP: assert property (sample_valid && st.sh_run && !smooth_en // RULE8
    |=> st.g_sm == $signed({st.g_app, 4'h0}))
    else $error("smoothing not bypassed");

  AST_HYST_HOLD: assert property (sample_valid && st.sh_run && hyst_hold |=> $stable(st.g_app)) // RULE9
    else $error("gain moved inside hysteresis band");

  AST_INIT_LOAD: assert property (sample_valid && !st.sh_run // RULE12
    |=> st.g_raw == $past(init_g) && st.g_app == $past(init_g))
    else $error("start-up gain not loaded");

  AST_INIT_MAP: assert property ((init_code != 5'h00 || init_g == -8'sh18) // RULE13
    && (init_code != 5'h06 || init_g == 8'sh00) && (init_code != 5'h12 || init_g == 8'sh30))
    else $error("start-up gain code mapped wrongly");

  AST_ATTACK: assert property (sample_valid && st.sh_run && !clip_now && step_due && high // RULE14
    && st.g_raw > dyr_pkg::GAIN_MIN |=> st.g_raw == $past(st.g_raw) - 8'sh01)
    else $error("gain did not fall on high level");

  AST_SHADOW: assert property (!sample_valid |=> $stable(st.sh_c1) && $stable(st.sh_c3) // RULE15
    && $stable(st.sh_c4))
    else $error("settings changed between sample boundaries");

  COV_CLIP: cover property (sample_valid && st.sh_run && clip_now);
  COV_FAST: cover property (sample_valid && st.sh_run && !high && fast_now);
  COV_START: cover property (sample_valid && !st.sh_run ##[1:50] sample_valid && st.sh_run);
  COV_NOSMOOTH: cover property (sample_valid && st.sh_run && !smooth_en && !hyst_en);

endmodule : dyr_range_ctrl

//--- verification/dyr_range_ctrl_tb.sv
/*
  Self-checking bench for the gain core: registers over APB, latency, start-up gain.
  Assumes the source model and a 25 MHz clock.
*/
`timescale 1ns/1ps
module dyr_range_ctrl_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, req, sample_valid, sample_out_valid, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  gain_attack_rate, normal_release_rate;
  logic [15:0] sample_in, sample_out, val;
  logic [16:0] exq[$];
  logic [16:0] nx;
  logic [15:0] hist[$];
  logic [11:0] ra[4] = '{12'h1e8, 12'h1ec, 12'h1f4, 12'h1f8};
  logic [15:0] rv[4] = '{16'h0000, 16'h0f10, 16'h0084, 16'h0600};
  logic [15:0] c3[3] = '{16'h0084, 16'h0004, 16'h0084};
  logic [15:0] c1[3] = '{16'h0d10, 16'h0f10, 16'h0f10};
  int          la[3] = '{0, 5, 9};
  logic [4:0]  sc[4] = '{5'h00, 5'h06, 5'h12, 5'h13};
  logic [7:0]  sg[4] = '{8'he8, 8'h00, 8'h30, 8'h30};
  integer      seed, mismatches, samples_checked, cyc, lat;

  dyr_range_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gain_attack_rate(gain_attack_rate), .normal_release_rate(normal_release_rate), .sample_in(sample_in),
    .sample_valid(sample_valid), .sample_out(sample_out), .sample_out_valid(sample_out_valid));
  dyr_src_model src (.pclk(pclk), .presetn(presetn), .req(req), .val(val), .sample_valid(sample_valid),
    .sample_in(sample_in));

  always #20 pclk = ~pclk;

  task end_of_test;
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Latency is judged against the bench's own record of what it sent.
  task smp(input logic c);
    logic [15:0] v;
    v = 16'($random(seed) % 2048);
    hist.push_front(v);
    @(posedge pclk);
    req <= 1'b1; val <= v;
    gain_attack_rate <= 4'h4 + 4'($random(seed) & 3);
    normal_release_rate <= 4'($random(seed) & 7);
    exq.push_back({c, hist[lat]});
    @(posedge pclk);
    req <= 1'b0;
    @(posedge pclk);
  endtask : smp

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      mismatches++;
      end_of_test();
    end
    if (sample_out_valid === 1'b1)
    begin
      if (exq.size() == 0)
        chk("unexpected output", 32'h0, 32'h1);
      else
      begin
        nx = exq.pop_front();
        if (nx[16])
          chk("sample_out", {16'h0, nx[15:0]}, {16'h0, sample_out});
      end
    end
  end

  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; req = 0; val = 0;
    gain_attack_rate = 4'h4; normal_release_rate = 4'h2; seed = 82; cyc = 0; lat = 0;
    mismatches = 0; samples_checked = 0;
    repeat (10) hist.push_front(16'h0000);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i])
    begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", {16'h0, rv[i]}, r);
      chk("mapped pslverr", 32'h0, {31'h0, e});
    end
    apb(1'b0, 12'h1f0, 32'h0);
    chk("unmapped pslverr", 32'h1, {31'h0, e});
    apb(1'b1, 12'h1ec, 32'h0000ffff);
    apb(1'b0, 12'h1ec, 32'h0);
    chk("enables mask", 32'h0f30, r);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 12'h1ec, {16'h0, c1[i]});
      apb(1'b1, 12'h1f4, {16'h0, c3[i]});
      repeat (12) smp(1'b0);
      lat = la[i];
      repeat (8) smp(1'b1);
    end
    apb(1'b1, 12'h1ec, 32'h00000910);
    foreach (sc[i])
    begin
      apb(1'b1, 12'h1f8, {19'h0, sc[i], 8'h00});
      repeat (2) smp(1'b0);
      apb(1'b0, 12'h1fc, 32'h0);
      chk("start-up gain", {24'h0, sg[i]}, {24'h0, r[7:0]});
    end
    apb(1'b1, 12'h1e8, 32'h1);
    repeat (20) smp(1'b0);
    apb(1'b0, 12'h1e8, 32'h0);
    chk("run", 32'h1, r);
    repeat (4) @(posedge pclk);
    chk("outputs pending", 32'h0, 32'(exq.size()));
    end_of_test();
  end
endmodule : dyr_range_ctrl_tb

//--- verification/dyr_src_model.sv
/*
  Sample source feeding the gain core with one-cycle sample pulses.
  Assumes the bench spaces requests at least two cycles apart.
*/
`timescale 1ns/1ps
module dyr_src_model (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bench request.
  input  wire logic        req,
  input  wire logic [15:0] val,
  // Stream towards the core.
  output logic             sample_valid,
  output logic      [15:0] sample_in
);
  // Idle data toggles so that stale data can never pass for a fresh sample.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_valid <= 1'b0;
      sample_in    <= 16'h0000;
    end
    else
    begin
      sample_valid <= req;
      sample_in    <= req ? val : ~sample_in;
    end
  end
endmodule : dyr_src_model
